// file: rtl/pin_function_pkg.sv
// Package: register map, reset values, write masks and pin function kinds
package pin_function_pkg;

  localparam int unsigned PORT_W = 16;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NREG   = 7;
  localparam int unsigned NCODE  = 4;

  // Register slots in the local file
  localparam logic [2:0] R_PA_DIR     = 3'h0;
  localparam logic [2:0] R_PB_DIR     = 3'h1;
  localparam logic [2:0] R_PA_FN_HIGH = 3'h2;
  localparam logic [2:0] R_PA_FN_LOW  = 3'h3;
  localparam logic [2:0] R_PB_FN_HIGH = 3'h4;
  localparam logic [2:0] R_PB_FN_LOW  = 3'h5;
  localparam logic [2:0] R_CAS_SEL    = 3'h6;

  // Printed register indices; byte address is four times the index
  localparam logic [27:0] REG_IDX [NREG] = '{
    28'h5ffffc4, 28'h5ffffc6, 28'h5ffffc8, 28'h5ffffca,
    28'h5ffffcc, 28'h5ffffce, 28'h5ffffee
  };

  // Power-on values
  localparam logic [15:0] RST [NREG] = '{
    16'h0000, 16'h0000, 16'h3302, 16'hff95, 16'h0000, 16'h0000, 16'h5fff
  };

  // Writable bits; the others keep their power-on value
  localparam logic [15:0] WMASK [NREG] = '{
    16'hffff, 16'hffff, 16'hfffd, 16'h55ff, 16'hffff, 16'hffff, 16'ha000
  };

  // Field positions
  localparam int unsigned PA_SINGLE_HI  = 8;
  localparam int unsigned PA_SINGLE_LO  = 4;
  localparam int unsigned PA_SINGLE_BIT = 8;
  localparam int unsigned HALF_PINS     = 8;
  localparam int unsigned CAS_UPPER_BIT = 15;
  localparam int unsigned CAS_LOWER_BIT = 13;

  // What a function code does with the pin
  typedef enum logic [2:0] {
    K_RSV   = 3'h0,
    K_IN    = 3'h1,
    K_INN   = 3'h2,
    K_OUT   = 3'h3,
    K_BIDIR = 3'h4,
    K_DIR   = 3'h5
  } kind_e;

endpackage

// file: rtl/pin_slot_mux.sv
// One multiplexed pin: output select, drive enable, input sync and gating
`timescale 1ns/1ps
`default_nettype none
module pin_slot_mux
  import pin_function_pkg::*;
#(
  parameter logic [3:0][2:0] KINDS = '0
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] sel,
  input  wire logic       dir,
  input  wire logic [3:0] slot_out,
  input  wire logic [3:0] slot_drive,
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe_n,
  output logic [3:0]      slot_in
);

  logic  in_s1_q;
  logic  in_s2_q;
  logic  drive_en;
  kind_e kind;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_q <= 1'b0;
      in_s2_q <= 1'b0;
    end else begin
      in_s1_q <= pin_in;
      in_s2_q <= in_s1_q;
    end
  end

  always_comb begin
    kind = kind_e'(KINDS[sel]);
    case (kind)
      K_OUT:   drive_en = 1'b1;
      K_BIDIR: drive_en = slot_drive[sel];
      K_DIR:   drive_en = dir;
      default: drive_en = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= slot_out[sel];
      pin_oe_n <= !drive_en;
    end
  end

  // Unselected and reserved slots see their idle level
  for (genvar i = 0; i < 4; i++) begin : g_slot
    localparam logic IDLE = (kind_e'(KINDS[i]) == K_INN);
    localparam logic SEES = (kind_e'(KINDS[i]) != K_RSV) && (kind_e'(KINDS[i]) != K_OUT);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        slot_in[i] <= IDLE;
      end else begin
        slot_in[i] <= (SEES && sel == 2'(i)) ? in_s2_q : IDLE;
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/pin_function_controller.sv
// Pin function controller: APB register file and per-pin function muxes
`timescale 1ns/1ps
`default_nettype none

module pin_function_controller
  import pin_function_pkg::*;
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic [pin_function_pkg::ADDR_W-1:0] paddr,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [pin_function_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic      [pin_function_pkg::DATA_W-1:0] prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [pin_function_pkg::PORT_W-1:0] pa_pin_in,
  output logic      [pin_function_pkg::PORT_W-1:0] pa_pin_out,
  output logic      [pin_function_pkg::PORT_W-1:0] pa_pin_oe_n,
  input  wire logic [3:0][pin_function_pkg::PORT_W-1:0] pa_fn_out,
  input  wire logic [3:0][pin_function_pkg::PORT_W-1:0] pa_fn_drive,
  output logic      [3:0][pin_function_pkg::PORT_W-1:0] pa_fn_in,
  input  wire logic [pin_function_pkg::PORT_W-1:0] pb_pin_in,
  output logic      [pin_function_pkg::PORT_W-1:0] pb_pin_out,
  output logic      [pin_function_pkg::PORT_W-1:0] pb_pin_oe_n,
  input  wire logic [3:0][pin_function_pkg::PORT_W-1:0] pb_fn_out,
  input  wire logic [3:0][pin_function_pkg::PORT_W-1:0] pb_fn_drive,
  output logic      [3:0][pin_function_pkg::PORT_W-1:0] pb_fn_in,
  input  wire logic                                chip_select_1_n,
  input  wire logic                                chip_select_3_n,
  input  wire logic                                column_strobe_upper_n,
  input  wire logic                                column_strobe_lower_n,
  output logic                                     cs1_pin_n,
  output logic                                     cs3_pin_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Function tables: [pin] = {code3, code2, code1, code0}

  localparam logic [3:0][2:0] PA_KIND [PORT_W] = '{
    {K_RSV, K_DIR, K_OUT, K_DIR},   // 0: cs4 / capcomp a0
    {K_RSV, K_OUT, K_OUT, K_DIR},   // 1: cs5 / row strobe
    {K_RSV, K_DIR, K_OUT, K_DIR},   // 2: cs6 / capcomp b0
    {K_RSV, K_INN, K_OUT, K_DIR},   // 3: chip select 7 / wait
    {K_RSV, K_RSV, K_OUT, K_DIR},   // 4: write strobe lower
    {K_RSV, K_RSV, K_OUT, K_DIR},   // 5: write strobe upper
    {K_RSV, K_RSV, K_OUT, K_DIR},   // 6: read strobe
    {K_RSV, K_RSV, K_OUT, K_DIR},   // 7: bus grant
    {K_RSV, K_RSV, K_INN, K_DIR},   // 8: bus request
    {K_OUT, K_RSV, K_OUT, K_DIR},   // 9: address hold / irq out
    {K_RSV, K_DIR, K_BIDIR, K_DIR}, // 10: parity_lower / timer1_capcomp_a
    {K_RSV, K_DIR, K_BIDIR, K_DIR}, // 11: parity_upper / timer1_capcomp_b
    {K_OUT, K_IN, K_INN, K_DIR},    // 12: irq0 / timer clock a / dack0
    {K_INN, K_IN, K_INN, K_DIR},    // 13: irq1 / timer_clock_b / dreq0
    {K_OUT, K_RSV, K_INN, K_DIR},   // 14: irq2 / dma_acknowledge_1
    {K_INN, K_RSV, K_INN, K_DIR}    // 15: interrupt_input_3 / dma_request_1
  };

  localparam logic [3:0][2:0] PB_KIND [PORT_W] = '{
    {K_RSV, K_OUT, K_DIR, K_DIR},   // 0: timer2 capcomp a / pattern
    {K_RSV, K_OUT, K_DIR, K_DIR},   // 1: timer2 capcomp b
    {K_RSV, K_OUT, K_DIR, K_DIR},   // 2: timer3 capcomp a
    {K_RSV, K_OUT, K_DIR, K_DIR},   // 3: timer3 capcomp b
    {K_RSV, K_OUT, K_DIR, K_DIR},   // 4: timer4 capcomp a
    {K_RSV, K_OUT, K_DIR, K_DIR},   // 5: timer4 capcomp b
    {K_OUT, K_OUT, K_IN, K_DIR},    // 6: timer clock c / extra out a
    {K_OUT, K_OUT, K_IN, K_DIR},    // 7: timer_clock_d / timer4_extra_out_b
    {K_RSV, K_OUT, K_INN, K_DIR},   // 8: serial receive 0 / pattern
    {K_RSV, K_OUT, K_OUT, K_DIR},   // 9: serial transmit 0
    {K_RSV, K_OUT, K_INN, K_DIR},   // 10: serial receive 1
    {K_RSV, K_OUT, K_OUT, K_DIR},   // 11: serial_transmit_1 / pattern_output_11
    {K_OUT, K_BIDIR, K_INN, K_DIR}, // 12: irq4 / serial clock 0 / pattern
    {K_OUT, K_BIDIR, K_INN, K_DIR}, // 13: irq5 / serial_clock_1 / pattern
    {K_OUT, K_RSV, K_INN, K_DIR},   // 14: irq6 / pattern
    {K_OUT, K_RSV, K_INN, K_DIR}    // 15: irq7 / pattern
  };

  //////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    decode = 4'h0;
    for (int i = 0; i < NREG; i++) begin
      if (a == {2'b00, REG_IDX[i], 2'b00}) begin
        decode = {1'b1, 3'(i)};
      end
    end
  endfunction

  // Port A mixes two-bit and one-bit fields
  function automatic logic [1:0] pa_code_of(input logic [15:0] hi,
                                            input logic [15:0] lo,
                                            input int          n);
    if (n > PA_SINGLE_HI) begin
      pa_code_of = hi[2*(n-HALF_PINS) +: 2];
    end else if (n == PA_SINGLE_HI) begin
      pa_code_of = {1'b0, hi[0]};
    end else if (n >= PA_SINGLE_LO) begin
      pa_code_of = {1'b0, lo[2*(n-PA_SINGLE_LO)+PA_SINGLE_BIT]};
    end else begin
      pa_code_of = lo[2*n +: 2];
    end
  endfunction

  function automatic logic [1:0] pb_code_of(input logic [15:0] hi,
                                            input logic [15:0] lo,
                                            input int          n);
    if (n >= HALF_PINS) begin
      pb_code_of = hi[2*(n-HALF_PINS) +: 2];
    end else begin
      pb_code_of = lo[2*n +: 2];
    end
  endfunction

  logic [15:0] regs_q [NREG];
  logic [31:0] prdata_q;
  logic [3:0]  dec;
  logic        dec_hit;
  logic [2:0]  dec_idx;
  logic        wr_en;
  logic [1:0]  pa_code [PORT_W];
  logic [1:0]  pb_code [PORT_W];
  logic        cs1_q;
  logic        cs3_q;
  logic        boot_q;

  assign dec     = decode(paddr);
  assign dec_hit = dec[3];
  assign dec_idx = dec[2:0];
  assign wr_en   = psel && penable && pwrite && dec_hit;

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped words

  // Unmapped words answer at once with an error, so a stray pointer cannot hang the bus
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !dec_hit;
  assign prdata  = prdata_q;

  // Captured in setup so the data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= dec_hit ? {16'h0, regs_q[dec_idx]} : 32'h0;
    end
  end

  // presetn is the power-on reset; nothing else clears these
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= RST[i];
      end
    end else if (wr_en) begin
      // Byte lanes 0 and 1 only; reserved bits hold their value
      for (int b = 0; b < 2; b++) begin
        if (pstrb[b]) begin
          regs_q[dec_idx][8*b +: 8] <= (regs_q[dec_idx][8*b +: 8] & ~WMASK[dec_idx][8*b +: 8])
                                     | (pwdata[8*b +: 8] & WMASK[dec_idx][8*b +: 8]);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-pin muxes for both ports

  for (genvar n = 0; n < PORT_W; n++) begin : g_pin
    logic [3:0] a_out;
    logic [3:0] a_drv;
    logic [3:0] a_in;
    logic [3:0] b_out;
    logic [3:0] b_drv;
    logic [3:0] b_in;

    // Selection is purely by register, never by chip mode
    assign pa_code[n] = pa_code_of(regs_q[R_PA_FN_HIGH], regs_q[R_PA_FN_LOW], n);
    assign pb_code[n] = pb_code_of(regs_q[R_PB_FN_HIGH], regs_q[R_PB_FN_LOW], n);

    for (genvar c = 0; c < NCODE; c++) begin : g_code
      assign a_out[c]       = pa_fn_out[c][n];
      assign a_drv[c]       = pa_fn_drive[c][n];
      assign pa_fn_in[c][n] = a_in[c];
      assign b_out[c]       = pb_fn_out[c][n];
      assign b_drv[c]       = pb_fn_drive[c][n];
      assign pb_fn_in[c][n] = b_in[c];
    end

    // Direction bit only reaches pins whose kind is K_DIR
    pin_slot_mux #(
      .KINDS(PA_KIND[n])
    ) u_pa (
      .pclk      (pclk),
      .presetn   (presetn),
      .sel       (pa_code[n]),
      .dir       (regs_q[R_PA_DIR][n]),
      .slot_out  (a_out),
      .slot_drive(a_drv),
      .pin_in    (pa_pin_in[n]),
      .pin_out   (pa_pin_out[n]),
      .pin_oe_n  (pa_pin_oe_n[n]),
      .slot_in   (a_in)
    );

    pin_slot_mux #(
      .KINDS(PB_KIND[n])
    ) u_pb (
      .pclk      (pclk),
      .presetn   (presetn),
      .sel       (pb_code[n]),
      .dir       (regs_q[R_PB_DIR][n]),
      .slot_out  (b_out),
      .slot_drive(b_drv),
      .pin_in    (pb_pin_in[n]),
      .pin_out   (pb_pin_out[n]),
      .pin_oe_n  (pb_pin_oe_n[n]),
      .slot_in   (b_in)
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Chip select / column strobe pins, output only

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs1_q <= 1'b1;
      cs3_q <= 1'b1;
    end else begin
      cs1_q <= regs_q[R_CAS_SEL][CAS_UPPER_BIT] ? column_strobe_upper_n : chip_select_1_n;
      cs3_q <= regs_q[R_CAS_SEL][CAS_LOWER_BIT] ? column_strobe_lower_n : chip_select_3_n;
    end
  end

  assign cs1_pin_n = cs1_q;
  assign cs3_pin_n = cs3_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  // Low only in the first cycle after power-on, for the reset value check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  sequence wr_acc(logic [2:0] i);
    psel && penable && pwrite && dec_hit && dec_idx == i;
  endsequence

  sequence rd_setup(logic [2:0] i);
    psel && !penable && !pwrite && dec_hit && dec_idx == i;
  endsequence

  dir_write_a: assert property (wr_acc(R_PA_DIR) ##0 pstrb[1:0] == 2'h3
    |=> regs_q[R_PA_DIR] == $past(pwdata[15:0]))
    else $error("direction write not stored");

  byte_lane_a: assert property (wr_acc(R_PB_DIR) ##0 pstrb[1:0] == 2'h1
    |=> regs_q[R_PB_DIR][15:8] == $past(regs_q[R_PB_DIR][15:8])
        && regs_q[R_PB_DIR][7:0] == $past(pwdata[7:0]))
    else $error("byte write touched the wrong lane");

  rsv_ones_a: assert property (rd_setup(R_PA_FN_LOW)
    |=> (prdata[15:0] & ~WMASK[R_PA_FN_LOW]) == (RST[R_PA_FN_LOW] & ~WMASK[R_PA_FN_LOW]))
    else $error("reserved bits do not read as one");

  reset_vals_a: assert property (!boot_q |-> regs_q[R_PA_FN_HIGH] == RST[R_PA_FN_HIGH]
    && regs_q[R_PA_FN_LOW] == RST[R_PA_FN_LOW] && regs_q[R_PA_DIR] == RST[R_PA_DIR]
    && regs_q[R_CAS_SEL] == RST[R_CAS_SEL] && regs_q[R_PB_FN_LOW] == RST[R_PB_FN_LOW])
    else $error("power-on value wrong");

  gpio_dir_a: assert property (pa_code[0] == 2'h0 && regs_q[R_PA_DIR][0]
    |=> !pa_pin_oe_n[0])
    else $error("gpio output not driven");

  capcomp_in_a: assert property (pa_code[2] == 2'h2 && !regs_q[R_PA_DIR][2]
    |=> pa_pin_oe_n[2])
    else $error("capture input driven");

  dreq_no_dir_a: assert property (pa_code[15] == 2'h3 && regs_q[R_PA_DIR][15]
    |=> pa_pin_oe_n[15])
    else $error("direction bit leaked into dma request pin");

  rsv_undriven_a: assert property (pa_code[11] == 2'h3
    |=> pa_pin_oe_n[11] && !pa_fn_in[3][11])
    else $error("reserved code drives pin");

  idle_irq_a: assert property (pa_code[15] != 2'h1
    ##1 pa_code[15] != 2'h1 |-> pa_fn_in[1][15])
    else $error("unselected interrupt input not idle");

  write_next_a: assert property (wr_acc(R_PA_FN_HIGH) ##0 pstrb[1:0] == 2'h3
    ##1 1'b1 |-> pa_code[15] == $past(pwdata[15:14]))
    else $error("function write not visible next cycle");

  cas_sel_a: assert property (regs_q[R_CAS_SEL][CAS_UPPER_BIT]
    |=> cs1_pin_n == $past(column_strobe_upper_n))
    else $error("column strobe not routed");

  unmapped_acc_a: assert property (psel && !penable && !dec_hit
    |=> (pwrite || prdata == 32'h0)
        && (!penable || pslverr))
    else $error("unmapped access answered wrongly");

  cas_lower_a: assert property (regs_q[R_CAS_SEL][CAS_LOWER_BIT]
    |=> cs3_pin_n == $past(column_strobe_lower_n))
    else $error("lower column strobe not routed");

  cs_direct_a: assert property (!regs_q[R_CAS_SEL][CAS_UPPER_BIT]
    |=> cs1_pin_n == $past(chip_select_1_n))
    else $error("chip select 1 not routed");

endmodule
`default_nettype wire

// file: dv/peripheral_model.sv
// Peripheral-side model: function outputs, drive requests and pin levels
`timescale 1ns/1ps
`default_nettype none
module peripheral_model (
  input  wire logic [15:0]      fn_pat,
  input  wire logic             drv,
  input  wire logic [15:0]      pa_ext,
  input  wire logic [15:0]      pb_ext,
  input  wire logic [15:0]      pa_pin_out,
  input  wire logic [15:0]      pa_pin_oe_n,
  input  wire logic [15:0]      pb_pin_out,
  input  wire logic [15:0]      pb_pin_oe_n,
  output logic      [3:0][15:0] pa_fn_out,
  output logic      [3:0][15:0] pa_fn_drive,
  output logic      [3:0][15:0] pb_fn_out,
  output logic      [3:0][15:0] pb_fn_drive,
  output logic      [15:0]      pa_pin_in,
  output logic      [15:0]      pb_pin_in
);
  // Distinct value per code so a wrong selection shows on the pin
  assign pa_fn_out   = {fn_pat ^ 16'hff00, fn_pat ^ 16'h00ff, ~fn_pat, fn_pat};
  assign pb_fn_out   = {fn_pat ^ 16'h00ff, fn_pat ^ 16'hff00, fn_pat, ~fn_pat};
  assign pa_fn_drive = {4{{16{drv}}}};
  assign pb_fn_drive = {4{{16{drv}}}};
  ////////////////////////////////////////////////////////////////
  // Wire level: the device wins where it drives, else the board
  assign pa_pin_in = (~pa_pin_oe_n & pa_pin_out) | (pa_pin_oe_n & pa_ext);
  assign pb_pin_in = (~pb_pin_oe_n & pb_pin_out) | (pb_pin_oe_n & pb_ext);
endmodule
`default_nettype wire

// file: dv/test_pin_function_controller.sv
// Testbench: APB register checks and pin routing scenarios
`timescale 1ns/1ps
`default_nettype none
module test_pin_function_controller;
  import pin_function_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, er, drv;
  logic [31:0]      paddr, pwdata, prdata, rd;
  logic [3:0]       pstrb;
  logic [15:0]      pa_pin_in, pa_pin_out, pa_pin_oe_n, pb_pin_in, pb_pin_out, pb_pin_oe_n;
  logic [3:0][15:0] pa_fn_out, pa_fn_drive, pa_fn_in, pb_fn_out, pb_fn_drive, pb_fn_in;
  logic             cs1_n, cs3_n, cas_u_n, cas_l_n, cs1_pin_n, cs3_pin_n;
  logic [15:0]      fn_pat, pa_ext, pb_ext, v;
  int               n_mismatch, n_compared, cyc;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  pin_function_controller pin_function_controller_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pa_pin_in(pa_pin_in), .pa_pin_out(pa_pin_out),
    .pa_pin_oe_n(pa_pin_oe_n), .pa_fn_out(pa_fn_out), .pa_fn_drive(pa_fn_drive),
    .pa_fn_in(pa_fn_in), .pb_pin_in(pb_pin_in), .pb_pin_out(pb_pin_out),
    .pb_pin_oe_n(pb_pin_oe_n), .pb_fn_out(pb_fn_out), .pb_fn_drive(pb_fn_drive),
    .pb_fn_in(pb_fn_in), .chip_select_1_n(cs1_n), .chip_select_3_n(cs3_n),
    .column_strobe_upper_n(cas_u_n), .column_strobe_lower_n(cas_l_n),
    .cs1_pin_n(cs1_pin_n), .cs3_pin_n(cs3_pin_n));

  peripheral_model peripheral_model_i (
    .fn_pat(fn_pat), .drv(drv), .pa_ext(pa_ext), .pb_ext(pb_ext),
    .pa_pin_out(pa_pin_out), .pa_pin_oe_n(pa_pin_oe_n), .pb_pin_out(pb_pin_out),
    .pb_pin_oe_n(pb_pin_oe_n), .pa_fn_out(pa_fn_out), .pa_fn_drive(pa_fn_drive),
    .pb_fn_out(pb_fn_out), .pb_fn_drive(pb_fn_drive), .pa_pin_in(pa_pin_in),
    .pb_pin_in(pb_pin_in));

  ////////////////////////////////////////////////////////////////
  task automatic results();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Printed offsets are word indices, so the byte address is four times them
  function automatic logic [31:0] ra(input int r);
    return {2'b00, REG_IDX[r], 2'b00};
  endfunction

  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic check_resets();
    for (int r = 0; r < NREG; r++) begin
      apb(ra(r), 1'b0, 32'h0, 4'h0);
      check("reset value", rd, {16'h0000, RST[r]});
    end
  endtask

  // Hang guard well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0;
    pwdata = 32'h0; pstrb = 4'h0; drv = 1'b0; fn_pat = 16'h5a3c;
    pa_ext = 16'h7fff; pb_ext = 16'h0f0f; cs1_n = 1'b1; cs3_n = 1'b1;
    cas_u_n = 1'b0; cas_l_n = 1'b0; n_mismatch = 0; n_compared = 0; cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_resets();
    for (int k = 0; k < 2; k++) begin
      v = k ? 16'hffff : 16'h0000;
      for (int r = 0; r < NREG; r++) begin
        apb(ra(r), 1'b1, {16'h0000, v}, 4'hf);
        apb(ra(r), 1'b0, 32'h0, 4'h0);
        check("rw bits", rd, {16'h0000, (v & WMASK[r]) | (RST[r] & ~WMASK[r])});
      end
    end
    apb(ra(R_PB_DIR), 1'b1, 32'h1234, 4'h1);
    apb(ra(R_PB_DIR), 1'b1, 32'habcd, 4'h2);
    apb(ra(R_PB_DIR), 1'b0, 32'h0, 4'h0);
    check("byte lanes", rd, 32'hab34);
    apb(32'h0, 1'b1, 32'hffff, 4'hf);
    check("unmapped write err", er, 1'b1);
    apb(32'h0, 1'b0, 32'h0, 4'h0);
    check("unmapped read", {er, rd[30:0]}, 32'h80000000);
    // Pin 0: general port obeys direction, chip select ignores it
    apb(ra(R_PA_DIR), 1'b1, 32'h0001, 4'hf);
    apb(ra(R_PA_FN_LOW), 1'b1, 32'hffa4, 4'hf);
    settle(2);
    check("pa0 gpio drive", {pa_pin_oe_n[2], pa_pin_oe_n[0], pa_pin_out[0]}, 32'h4);
    apb(ra(R_PA_DIR), 1'b1, 32'h0000, 4'hf);
    settle(2);
    check("pa0 gpio input", pa_pin_oe_n[0], 1'b1);
    apb(ra(R_PA_FN_LOW), 1'b1, 32'hff95, 4'hf);
    settle(2);
    check("pa0 chip select", {pa_pin_oe_n[0], pa_pin_out[0]}, 32'h1);
    // Pin 15 through all its codes, board holding it low
    apb(ra(R_PA_DIR), 1'b1, 32'h8000, 4'hf);
    apb(ra(R_PA_FN_HIGH), 1'b1, 32'h7302, 4'hf);
    settle(5);
    check("pa15 irq in", {pa_pin_oe_n[15], pa_fn_in[1][15]}, 32'h2);
    apb(ra(R_PA_FN_HIGH), 1'b1, 32'hb302, 4'hf);
    settle(5);
    check("pa15 reserved", {pa_pin_oe_n[15], pa_fn_in[1][15], pa_fn_in[3][15]}, 32'h7);
    apb(ra(R_PA_FN_HIGH), 1'b1, 32'hf302, 4'hf);
    settle(5);
    check("pa15 dma req", {pa_fn_in[1][15], pa_fn_in[3][15]}, 32'h2);
    apb(ra(R_PA_FN_HIGH), 1'b1, 32'h3302, 4'hf);
    settle(2);
    check("pa15 gpio out", {pa_pin_oe_n[15], pa_pin_out[15]}, 32'h0);
    // Column strobes replace chip selects only when selected
    apb(ra(R_CAS_SEL), 1'b1, 32'h0000, 4'hf);
    settle(3);
    check("cs selected", {cs1_pin_n, cs3_pin_n}, 32'h3);
    apb(ra(R_CAS_SEL), 1'b1, 32'ha000, 4'hf);
    settle(3);
    check("cas selected", {cs1_pin_n, cs3_pin_n}, 32'h0);
    // Port B: pattern, transmit, serial clock idle and then driven
    apb(ra(R_PB_FN_HIGH), 1'b1, 32'hc840, 4'hf);
    settle(5);
    check("pb routing", {pb_pin_oe_n[15], pb_pin_out[15], pb_pin_oe_n[13], pb_fn_in[2][13],
          pb_pin_oe_n[11], pb_pin_out[11]}, 32'h9);
    @(posedge pclk);
    drv <= 1'b1;
    settle(5);
    check("pb sck drive", {pb_pin_oe_n[13], pb_pin_out[13], pb_fn_in[2][13]}, 32'h3);
    // Second power-on in mid-run brings every register back
    apb(ra(R_PA_DIR), 1'b1, 32'h00ff, 4'hf);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_resets();
    results();
  end
endmodule
`default_nettype wire
